//--- hw/pjk_pin_function.sv
// Purpose: Pin function multiplexer for ports J and K with Wishbone
//          register access.
// Assumes: Reset covers power-on (not watchdog) reset and hardware standby;
//          software standby and sleep assert nothing here.
// Notes:   Port J direction lives elsewhere; its I/O request arrives ready.
//          Pin outputs are combinational from the registers and the timer
//          requests, so a mode change shows one cycle after the write.
//          Pin inputs pass two flip-flops before any steering reads them;
//          consumers therefore see a pin level two cycles late.
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "pjk_defines.svh"

module pjk_pin_function (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // Port J general I/O and timer capture/compare side
  input  wire pjk_pkg::pjk_out_req_t   port_j_gpio_req,
  input  wire pjk_pkg::pjk_out_req_t   capture_compare_req,
  output logic      [15:0]             capture_compare_in,
  output logic      [15:0]             port_j_gpio_in,
  // Port K general I/O data and one-shot timer side
  input  wire logic [15:0]             port_k_gpio_out,
  input  wire logic [15:0]             one_shot_out,
  output logic      [15:0]             port_k_gpio_in,
  // Pins
  input  wire logic [15:0]             port_j_pin_in,
  output pjk_pkg::pjk_pin_drive_t      port_j_pin,
  input  wire logic [15:0]             port_k_pin_in,
  output pjk_pkg::pjk_pin_drive_t      port_k_pin
);
  import pjk_pkg::*;

  // Register map, one 32-bit word per register, data in bits [15:0]:
  //   0x00  port J high select  mode bits for pins 8 to 15
  //   0x04  port J low select   mode bits for pins 0 to 7
  //   0x08  port K direction    one bit per pin, one drives
  //   0x0C  port K high select  mode bits for pins 8 to 15
  //   0x10  port K low select   mode bits for pins 0 to 7
  // Any other address acks, reads zero and drops writes, so software
  // probing the space never stalls the bus.
  // In a select register pin n (mod 8) owns bit 2n; bit 2n+1 is spare,
  // never stores and reads back zero.
  // Byte lanes: sel[0] writes bits [7:0], sel[1] bits [15:8]; sel[3:2]
  // address nothing here and are ignored.
  // Timing: a request is seen at one edge and acked at the next; the
  // write lands at the edge where ack is sampled high, and a new mode
  // shows on the pins in the cycle after it.
  // Limitation: software standby and sleep have no input here, so they
  // leave every register as it was; only sys_rst clears them.

  // Registers
  logic [15:0] port_j_high_function_select;
  logic [15:0] port_j_low_function_select;
  logic [15:0] port_k_direction;
  logic [15:0] port_k_high_function_select;
  logic [15:0] port_k_low_function_select;
  logic [15:0] pin_sync_j1;
  logic [15:0] pin_sync_j2;
  logic [15:0] pin_sync_k1;
  logic [15:0] pin_sync_k2;

  // Bus decode; ack is one cycle after request, dropped the cycle after
  wire        bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Write lands at the ack edge, while the master still holds the request
  wire        bus_wr    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        hit_jh    = wb_adr_i == `PJK_ADDR_J_HIGH_SEL;
  wire        hit_jl    = wb_adr_i == `PJK_ADDR_J_LOW_SEL;
  wire        hit_kd    = wb_adr_i == `PJK_ADDR_K_DIR;
  wire        hit_kh    = wb_adr_i == `PJK_ADDR_K_HIGH_SEL;
  wire        hit_kl    = wb_adr_i == `PJK_ADDR_K_LOW_SEL;
  wire [15:0] sel_mask  = lane_mask & `PJK_SEL_WRITE_MASK;
  wire [15:0] wdat      = wb_dat_i[15:0];

  // Per-register write strobes
  wire        wr_jh     = bus_wr & hit_jh;
  wire        wr_jl     = bus_wr & hit_jl;
  wire        wr_kd     = bus_wr & hit_kd;
  wire        wr_kh     = bus_wr & hit_kh;
  wire        wr_kl     = bus_wr & hit_kl;

  // Next values: byte-lane merge, reserved bits hold their reset zero
  wire [15:0] next_jh = (port_j_high_function_select & ~sel_mask)
                        | (wdat & sel_mask);
  wire [15:0] next_jl = (port_j_low_function_select & ~sel_mask)
                        | (wdat & sel_mask);
  wire [15:0] next_kd = (port_k_direction & ~lane_mask)
                        | (wdat & lane_mask);
  wire [15:0] next_kh = (port_k_high_function_select & ~sel_mask)
                        | (wdat & sel_mask);
  wire [15:0] next_kl = (port_k_low_function_select & ~sel_mask)
                        | (wdat & sel_mask);

  // Read mux; unmapped addresses read zero but still ack
  wire [15:0] rd_val = hit_jh ? port_j_high_function_select :
                       hit_jl ? port_j_low_function_select  :
                       hit_kd ? port_k_direction            :
                       hit_kh ? port_k_high_function_select :
                       hit_kl ? port_k_low_function_select  : 16'h0000;

  // Bus handshake and read data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `PJK_READ_UNMAPPED;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= {16'h0000, rd_val};
      end
    end
  end

  // Register file; standby and sleep have no effect, so contents survive.
  // One short process per register keeps each reset and load easy to see.

  // Port J high select; odd bits never load, so they read back zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_j_high_function_select <= `PJK_RESET_VALUE;
    end else if (wr_jh) begin
      port_j_high_function_select <= next_jh;
    end
  end

  // Port J low select; pins 0 to 7 of the capture/compare port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_j_low_function_select <= `PJK_RESET_VALUE;
    end else if (wr_jl) begin
      port_j_low_function_select <= next_jl;
    end
  end

  // Port K direction; all sixteen bits store
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_k_direction <= `PJK_RESET_VALUE;
    end else if (wr_kd) begin
      port_k_direction <= next_kd;
    end
  end

  // Port K high select; pins 8 to 15 of the one-shot port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_k_high_function_select <= `PJK_RESET_VALUE;
    end else if (wr_kh) begin
      port_k_high_function_select <= next_kh;
    end
  end

  // Port K low select; pins 0 to 7 of the one-shot port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_k_low_function_select <= `PJK_RESET_VALUE;
    end else if (wr_kl) begin
      port_k_low_function_select <= next_kl;
    end
  end

  // Pin input synchronisers; stage one feeds stage two only, so nothing
  // downstream can see a metastable first-stage value.

  // Port J pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_sync_j1 <= 16'h0000;
      pin_sync_j2 <= 16'h0000;
    end else begin
      pin_sync_j1 <= port_j_pin_in;
      pin_sync_j2 <= pin_sync_j1;
    end
  end

  // Port K pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_sync_k1 <= 16'h0000;
      pin_sync_k2 <= 16'h0000;
    end else begin
      pin_sync_k1 <= port_k_pin_in;
      pin_sync_k2 <= pin_sync_k1;
    end
  end

  // Per-pin steering wires, one bit per pin, filled by the loop below
  wire [15:0] j_mode;      // Pin J n carries its timer channel
  wire [15:0] k_mode;      // Pin K n carries its one-shot output
  wire [15:0] j_out;       // Level offered to pin J n
  wire [15:0] j_oe;        // Pin J n driven
  wire [15:0] j_to_timer;  // Synced pin J level seen by the timer
  wire [15:0] j_to_gpio;   // Synced pin J level seen by port J I/O
  wire [15:0] k_out;       // Level offered to pin K n
  wire [15:0] k_oe;        // Pin K n driven
  wire [15:0] k_to_gpio;   // Synced pin K level seen by port K I/O

  // One slice per pin; a slice reads its own mode bit and nothing else,
  // so a write to one pin's field never disturbs a neighbour.
  genvar n;
  generate
    for (n = 0; n < 16; n = n + 1) begin : g_pin
      // Mode bit sits at the even position 2*(n mod 8) of its register
      localparam int MBIT = `PJK_MODE_BIT_STEP * (n % 8);

      // Lower eight pins use the low select, upper eight the high one
      wire j_sel_lo  = port_j_low_function_select[MBIT];
      wire j_sel_hi  = port_j_high_function_select[MBIT];
      wire k_sel_lo  = port_k_low_function_select[MBIT];
      wire k_sel_hi  = port_k_high_function_select[MBIT];
      wire j_md      = (n < 8) ? j_sel_lo : j_sel_hi;
      wire k_md      = (n < 8) ? k_sel_lo : k_sel_hi;

      // Port J sources for this pin
      wire j_tmr_val = capture_compare_req.value[n];
      wire j_tmr_en  = capture_compare_req.enable[n];
      wire j_io_val  = port_j_gpio_req.value[n];
      wire j_io_en   = port_j_gpio_req.enable[n];

      // Port K sources for this pin
      wire k_tmr_val = one_shot_out[n];
      wire k_io_val  = port_k_gpio_out[n];
      wire k_io_dir  = port_k_direction[n];

      assign j_mode[n] = j_md;
      assign k_mode[n] = k_md;

      // Port J: the timer channel owns value and enable in timer mode
      assign j_out[n] = j_md ? j_tmr_val : j_io_val;
      assign j_oe[n]  = j_md ? j_tmr_en : j_io_en;

      // Input goes to one consumer only; the other sees a steady zero,
      // so an I/O read never shows capture activity and the reverse
      assign j_to_timer[n] = j_md & pin_sync_j2[n];
      assign j_to_gpio[n]  = ~j_md & pin_sync_j2[n];

      // Port K: one-shot pins always drive, direction counts in I/O only
      assign k_out[n] = k_md ? k_tmr_val : k_io_val;
      assign k_oe[n]  = k_md | k_io_dir;

      // One-shot pins are outputs, so only I/O mode passes the level in
      assign k_to_gpio[n] = ~k_md & pin_sync_k2[n];
    end
  endgenerate

  // Pin and consumer outputs assembled from the per-pin slices.
  // Whole-struct assignments keep each output port to a single driver.
  assign port_j_pin         = {j_out, j_oe};
  assign port_k_pin         = {k_out, k_oe};
  assign capture_compare_in = j_to_timer;
  assign port_j_gpio_in     = j_to_gpio;
  assign port_k_gpio_in     = k_to_gpio;

  // Hazard: the pin enables switch in the cycle after a mode write with
  // no dead time; a board that cannot take a brief overlap between the
  // timer and I/O drivers must stop the timer output before the change.

endmodule

//--- common/pjk_defines.svh
// Purpose: Register offsets, field positions and reset values for the
//          port J/K pin function control block.
// Assumes: Classic Wishbone, 32-bit data, byte addresses, one word each.
// Notes:   Offsets are chosen locally; registers hold 16 bits in [15:0].
`ifndef PJK_DEFINES_SVH
`define PJK_DEFINES_SVH

`define PJK_ADDR_J_HIGH_SEL  8'h00
`define PJK_ADDR_J_LOW_SEL   8'h04
`define PJK_ADDR_K_DIR       8'h08
`define PJK_ADDR_K_HIGH_SEL  8'h0C
`define PJK_ADDR_K_LOW_SEL   8'h10
`define PJK_SEL_WRITE_MASK   16'h5555
`define PJK_RESET_VALUE      16'h0000
`define PJK_MODE_BIT_STEP    2
`define PJK_READ_UNMAPPED    32'h0000_0000

`endif

//--- common/pjk_pkg.sv
// Purpose: Types shared by the port J/K pin function control block.
// Assumes: Sixteen pins per port.
// Notes:   Pin groups travel as packed structs.
package pjk_pkg;

  // Pin-side signals of one 16-bit port
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } pjk_pin_drive_t;

  // Timer-side or I/O-side output request for 16 pins
  typedef struct packed {
    logic [15:0] value;
    logic [15:0] enable;
  } pjk_out_req_t;

endpackage

//--- testbench/pjk_timer_model.sv
// Purpose: Timer unit and external pin model for the pin mux.
// Assumes: Values move only when load is seen at an edge.
// Notes:   Held steady so the 2-flop input sync can settle.
`timescale 1ns/1ps
module pjk_timer_model (
  // Clock and control
  input  wire logic [0:0]             clk,
  input  wire logic [0:0]             load,
  input  wire logic [31:0]            seed,
  // Timer and pin side
  output pjk_pkg::pjk_out_req_t       capture_compare_req,
  output logic      [15:0]            one_shot_out,
  output logic      [15:0]            port_j_pin_in,
  output logic      [15:0]            port_k_pin_in
);
  import pjk_pkg::*;
  logic [31:0] r = 32'h0000_0000;
  // New timer and pin pattern on request
  always @(posedge clk) if (load) r <= seed;
  // Timer outputs stay busy on every lane, mode or not
  assign capture_compare_req = {r[15:0], ~r[31:16]};
  assign one_shot_out        = r[31:16] ^ r[15:0];
  assign port_j_pin_in       = ~r[15:0];
  assign port_k_pin_in       = r[31:16];
endmodule

//--- testbench/pjk_pin_function_asserts.sv
// Purpose: Port assertions for the pin function block.
// Assumes: One-cycle Wishbone answer.
// Notes:   Sees ports only, so register state is not shadowed.
`timescale 1ns/1ps
`include "pjk_defines.svh"
module pjk_pin_function_asserts (
  // Clock, reset and Wishbone
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Port K sources and pins
  input wire logic [15:0]             port_k_gpio_out,
  input wire logic [15:0]             one_shot_out,
  input wire pjk_pkg::pjk_pin_drive_t port_k_pin
);
  import pjk_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Read answers; space past the last select reads as nothing
  wire rd  = wb_ack_o && !wb_we_i;
  wire far = wb_adr_i > `PJK_ADDR_K_LOW_SEL;
  wire kd  = wb_adr_i == `PJK_ADDR_K_DIR;
  sequence s_kdir;
    wb_cyc_i && wb_stb_i && wb_we_i && kd && wb_sel_i[1:0] == 2'b11
      ##1 wb_ack_o;
  endsequence
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pls; wb_ack_o |=> !wb_ack_o; endproperty
  a_pls: assert property (p_pls) else $error("ack long");
  property p_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_cause: assert property (p_cause) else $error("ack unasked");
  property p_rd;
    rd |-> (wb_dat_o & (kd ? 32'hFFFF_0000 : 32'hFFFF_AAAA)) == 0;
  endproperty
  a_rd: assert property (p_rd) else $error("reserved set");
  property p_um; rd && far |-> wb_dat_o == 0; endproperty
  a_um: assert property (p_um) else $error("unmapped data");
  property p_rst; $fell(sys_rst) |-> port_k_pin.oe == 0; endproperty
  a_rst: assert property (p_rst) else $error("oe after reset");
  // Any driven lane carries either the I/O data or the one-shot level
  property p_kmux;
    ((port_k_pin.out ^ port_k_gpio_out) & (port_k_pin.out ^ one_shot_out)
      & port_k_pin.oe) == 0;
  endproperty
  a_kmux: assert property (p_kmux) else $error("k source");
  property p_kdir;
    s_kdir |=> ($past(wb_dat_i[15:0]) & ~port_k_pin.oe) == 0;
  endproperty
  a_kdir: assert property (p_kdir) else $error("k dir");
endmodule
bind pjk_pin_function pjk_pin_function_asserts pjk_pin_function_asserts_i (.*);

//--- testbench/test_pjk_pin_function.sv
// Purpose: Self-checking bench for the pin function block.
// Assumes: One-cycle Wishbone answer, xorshift stimulus.
// Notes:   Model registers shadow writes; reads and pins compared.
`timescale 1ns/1ps
`include "pjk_defines.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("FAIL %0t mismatch", $time); end end
module test_pjk_pin_function;
  import pjk_pkg::*;
  // Stimulus, answers and model state
  logic           clk = 1'b0, sys_rst = 1'b1, load = 1'b0, wb_ack_o;
  logic           wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]     wb_adr_i = 8'h00, a;
  logic [3:0]     wb_sel_i = 4'h0;
  logic [31:0]    wb_dat_i = 32'h0000_0000, seed = 32'h0000_0000;
  logic [31:0]    x = 32'h0000_79C5, wb_dat_o, rd, d;
  logic [15:0]    port_k_gpio_out = 16'h0000, one_shot_out, port_j_pin_in;
  logic [15:0]    port_k_pin_in, capture_compare_in, port_j_gpio_in;
  logic [15:0]    port_k_gpio_in, m [5];
  pjk_out_req_t   port_j_gpio_req = 32'h0000_0000, capture_compare_req;
  pjk_pin_drive_t port_j_pin, port_k_pin;
  int             err_count = 0, num_checks = 0, cycles = 0;
  pjk_pin_function pjk_pin_function_i (.*);
  pjk_timer_model pjk_timer_model_i (.*);
  always #4 clk = ~clk;
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      err_count++;
      give_verdict();
    end
  end
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // One classic cycle, then the shadow model follows or checks it
  task automatic wb(input logic we, input logic [7:0] a_i,
                    input logic [31:0] d_i, input logic [3:0] s);
    logic [15:0] bm, er;
    bm = {{8{s[1]}}, {8{s[0]}}} &
         (a_i == `PJK_ADDR_K_DIR ? 16'hFFFF : `PJK_SEL_WRITE_MASK);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a_i;
    wb_dat_i <= d_i;
    wb_sel_i <= s;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (we && a_i <= `PJK_ADDR_K_LOW_SEL)
      m[a_i >> 2] = (m[a_i >> 2] & ~bm) | (d_i[15:0] & bm);
    er = far(a_i) ? 16'h0000 : m[a_i >> 2];
    if (!we) `CHK(rd, {16'h0000, er})
  endtask
  function automatic logic far(input logic [7:0] a_i);
    return a_i > `PJK_ADDR_K_LOW_SEL;
  endfunction
  // Pin drive and input routing against the mode bits
  task automatic pins();
    logic [15:0] jm, km, ko, jo, kv, jv;
    for (int n = 0; n < 16; n++) begin
      jm[n] = m[n < 8 ? 1 : 0][2 * (n % 8)];
      km[n] = m[n < 8 ? 4 : 3][2 * (n % 8)];
    end
    ko = km | m[2];
    jo = capture_compare_req.enable & jm | port_j_gpio_req.enable & ~jm;
    kv = (one_shot_out & km | port_k_gpio_out & ~km) & ko;
    jv = capture_compare_req.value & jm | port_j_gpio_req.value & ~jm;
    jv = jv & jo;
    `CHK(port_k_pin.oe, ko)
    `CHK(port_k_pin.out & ko, kv)
    `CHK(port_j_pin.oe, jo)
    `CHK(port_j_pin.out & jo, jv)
    `CHK(capture_compare_in, port_j_pin_in & jm)
    `CHK(port_j_gpio_in, port_j_pin_in & ~jm)
    `CHK(port_k_gpio_in, port_k_pin_in & ~km)
  endtask
  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Random traffic with a second reset in mid-run
  initial begin
    for (int i = 0; i < 5; i++) m[i] = 16'h0000;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    for (int it = 0; it < 60; it++) begin
      if (it == 40) begin
        @(posedge clk) sys_rst <= 1'b1;
        @(posedge clk) sys_rst <= 1'b0;
        for (int i = 0; i < 5; i++) m[i] = 16'h0000;
      end
      if (it % 40 == 0)
        for (int i = 0; i < 6; i++)
          wb(1'b0, 8'(i * 4), 32'h0000_0000, 4'hF);
      seed            <= rnd();
      port_j_gpio_req <= rnd();
      port_k_gpio_out <= 16'(rnd());
      load            <= 1'b1;
      @(posedge clk) load <= 1'b0;
      a = 8'((rnd() % 6) << 2);
      d = rnd();
      if (it[0]) d = d & 32'h0000_5555;
      wb(1'b1, a, d, 4'(rnd() & 3));
      wb(1'b0, a, 32'h0000_0000, 4'hF);
      pins();
    end
    give_verdict();
  end
endmodule
